// *** lin_otp_params.svh ***
// Frame constants, register offsets and reset values of the settings readback block
`ifndef LIN_OTP_PARAMS_SVH
`define LIN_OTP_PARAMS_SVH
`define LOT_ID_MASTER_REQ  8'h3C
`define LOT_PID_SLAVE_RESP 8'h7D
`define LOT_APP_CMD        8'h80
`define LOT_CODE_FIRST     7'h04
`define LOT_CODE_SECOND    7'h05
`define LOT_FILL           8'hFF
`define LOT_FRAME_BYTES    4'h9
`define LOT_LAST_IDX       4'h8
`define LOT_REG_CTRL       4'h0
`define LOT_REG_STATUS     4'h4
`define LOT_CTRL_RST       8'h01
`define LOT_STAT_CSUM_ERR  2
`endif

// *** lin_otp_pkg.sv ***
// Types shared by the settings readback block
`default_nettype none
package lin_otp_pkg;
	typedef struct packed {
		logic [5:0] node_address;
		logic       low_rate;
		logic       diagnostics_off_fuse;
		logic       default_setting;
		logic       error_report_off;
		logic       thermal_warning_level;
		logic       otp_lock_first;
		logic       commands_disable_fuse;
		logic [7:0] a11;
		logic [7:0] a12;
		logic [7:0] a13;
		logic [7:0] a21;
		logic [7:0] a22;
		logic [7:0] a23;
		logic [7:0] a31;
		logic [7:0] a32;
		logic [7:0] a33;
		logic       otp_lock_second;
		logic       modulation_rate_select;
		logic       thermal_control_enable;
		logic [3:0] group_number;
	} otp_settings_t;

	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} lin_beat_t;
endpackage
`default_nettype wire

// *** lin_otp_settings_readback.sv ***
// Settings readback command pair: request decode and in-frame response
//
// The strobed register port and the placing of the registers are this design's own decisions.
`default_nettype none
`include "lin_otp_params.svh"

// Contract
// - Codes 0x04/0x05, address with top ones, 0xFF fill
// - Request on 0x3C with 0x80, reply on 0x7D
// - Classic checksum over data bytes only
// - First reply: address, rate, diagnostics, ones
// - First reply bytes 4 and 5 fields
// - First reply bytes 6-8 are a11-a13
// - Disable fuse makes device ignore this command
module lin_otp_settings_readback (
	input  wire logic                        mclk_in,
	input  wire logic                        nrst_in,
	input  wire logic                        ce_in,
	input  wire lin_otp_pkg::otp_settings_t  otp_in,
	input  wire logic                        hdr_valid_in,
	input  wire logic [7:0]                  hdr_id_in,
	input  wire lin_otp_pkg::lin_beat_t      rx_in,
	input  wire logic                        tx_ready_in,
	output logic                             tx_valid_out,
	output logic [7:0]                       tx_byte_out,
	input  wire logic [3:0]                  reg_addr_in,
	input  wire logic [7:0]                  reg_wdata_in,
	input  wire logic                        reg_we_in,
	input  wire logic                        reg_re_in,
	output logic [7:0]                       reg_rdata_out
);
	logic       rx_active_reg;
	logic [3:0] rx_idx_reg;
	logic [7:0] rx_sum_reg;
	logic [7:0] rx_app_reg;
	logic [7:0] rx_code_reg;
	logic [7:0] rx_addr_reg;
	logic       armed_reg;
	logic       half_reg;
	logic       tx_active_reg;
	logic [3:0] tx_idx_reg;
	logic [7:0] tx_byte_reg;
	logic [7:0] tx_sum_reg;
	logic [7:0] ctrl_reg;
	logic       csum_err_reg;
	logic [7:0] rdata_reg;
	logic [7:0] resp [0:8];
	logic       req_hdr;
	logic       resp_hdr;
	logic       rx_last;
	logic       req_ok;
	logic       csum_ok;
	logic       tx_step;

	function automatic logic [7:0] classic_add(input logic [7:0] acc, input logic [7:0] b);
		logic [8:0] t;
		t = {1'b0, acc} + {1'b0, b};
		return t[7:0] + {7'h00, t[8]};
	endfunction

	assign req_hdr  = ce_in && hdr_valid_in && (hdr_id_in == `LOT_ID_MASTER_REQ);
	assign resp_hdr = ce_in && hdr_valid_in && (hdr_id_in == `LOT_PID_SLAVE_RESP);
	assign rx_last  = ce_in && rx_active_reg && rx_in.valid && (rx_idx_reg == `LOT_LAST_IDX);
	assign csum_ok  = (~rx_sum_reg == rx_in.data);
	// Command byte, code, address and checksum are checked; fill bytes are tolerated
	assign req_ok   = csum_ok && (rx_app_reg == `LOT_APP_CMD)
		&& ((rx_code_reg == {1'b1, `LOT_CODE_FIRST}) || (rx_code_reg == {1'b1, `LOT_CODE_SECOND}))
		&& (rx_addr_reg == {2'b11, otp_in.node_address}) && !otp_in.commands_disable_fuse;
	assign tx_step  = ce_in && tx_active_reg && tx_ready_in;

	// Reply image; the checksum entry covers data bytes only
	always_comb begin
		logic [7:0] acc;
		acc = 8'h00;
		resp[0] = {2'b11, otp_in.node_address};
		if (!half_reg) begin
			resp[1] = {6'h3F, otp_in.low_rate, otp_in.diagnostics_off_fuse};
			resp[2] = `LOT_FILL;
			resp[3] = {otp_in.default_setting, otp_in.error_report_off, otp_in.thermal_warning_level, 5'h1F};
			resp[4] = {otp_in.otp_lock_first, otp_in.commands_disable_fuse, otp_in.node_address};
			resp[5] = otp_in.a11;
			resp[6] = otp_in.a12;
			resp[7] = otp_in.a13;
		end else begin
			resp[1] = otp_in.a21;
			resp[2] = otp_in.a22;
			resp[3] = otp_in.a23;
			resp[4] = otp_in.a31;
			resp[5] = otp_in.a32;
			resp[6] = otp_in.a33;
			resp[7] = {otp_in.otp_lock_second, otp_in.modulation_rate_select, 1'b1,
				otp_in.thermal_control_enable, otp_in.group_number};
		end
		for (int i = 0; i < 8; i++) begin
			acc = classic_add(acc, resp[i]);
		end
		resp[8] = ~acc;
	end

	// Request reception; any new header abandons a partial request
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rx_active_reg <= 1'b0;
			rx_idx_reg    <= 4'h0;
			rx_sum_reg    <= 8'h00;
			rx_app_reg    <= 8'h00;
			rx_code_reg   <= 8'h00;
			rx_addr_reg   <= 8'h00;
		end else if (ce_in) begin
			if (hdr_valid_in) begin
				rx_active_reg <= req_hdr && ctrl_reg[0];
				rx_idx_reg    <= 4'h0;
				rx_sum_reg    <= 8'h00;
			end else if (rx_active_reg && rx_in.valid) begin
				rx_idx_reg <= rx_idx_reg + 4'h1;
				rx_sum_reg <= classic_add(rx_sum_reg, rx_in.data);
				if (rx_idx_reg == 4'h0) begin
					rx_app_reg <= rx_in.data;
				end
				if (rx_idx_reg == 4'h1) begin
					rx_code_reg <= rx_in.data;
				end
				if (rx_idx_reg == 4'h2) begin
					rx_addr_reg <= rx_in.data;
				end
				if (rx_idx_reg == `LOT_LAST_IDX) begin
					rx_active_reg <= 1'b0;
				end
			end
		end
	end

	// Arming and half selection; a response header always consumes the arm
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			armed_reg <= 1'b0;
			half_reg  <= 1'b0;
		end else if (ce_in) begin
			if (resp_hdr) begin
				armed_reg <= 1'b0;
			end else if (rx_last) begin
				armed_reg <= req_ok;
				if (req_ok) begin
					half_reg <= (rx_code_reg[6:0] == `LOT_CODE_SECOND);
				end
			end
		end
	end

	// Response transmission, one byte per accepted ready
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			tx_active_reg <= 1'b0;
			tx_idx_reg    <= 4'h0;
			tx_byte_reg   <= 8'h00;
		end else if (ce_in) begin
			if (hdr_valid_in) begin
				tx_active_reg <= resp_hdr && armed_reg && ctrl_reg[0];
				tx_idx_reg    <= 4'h0;
				tx_byte_reg   <= resp[0];
			end else if (tx_step) begin
				if (tx_idx_reg == `LOT_LAST_IDX) begin
					tx_active_reg <= 1'b0;
				end else begin
					tx_idx_reg  <= tx_idx_reg + 4'h1;
					tx_byte_reg <= resp[tx_idx_reg + 4'h1];
				end
			end
		end
	end

	assign tx_valid_out = tx_active_reg;
	assign tx_byte_out  = tx_byte_reg;

	// Control register; bit 0 enables the command
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			ctrl_reg <= `LOT_CTRL_RST;
		end else if (ce_in && reg_we_in && reg_addr_in == `LOT_REG_CTRL) begin
			ctrl_reg <= reg_wdata_in;
		end
	end

	// Sticky checksum error; a new error wins over a write-one clear
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			csum_err_reg <= 1'b0;
		end else if (ce_in) begin
			if (rx_last && !csum_ok) begin
				csum_err_reg <= 1'b1;
			end else if (reg_we_in && reg_addr_in == `LOT_REG_STATUS && reg_wdata_in[`LOT_STAT_CSUM_ERR]) begin
				csum_err_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rdata_reg <= 8'h00;
		end else if (ce_in) begin
			if (reg_re_in && reg_addr_in == `LOT_REG_CTRL) begin
				rdata_reg <= ctrl_reg;
			end else if (reg_re_in && reg_addr_in == `LOT_REG_STATUS) begin
				rdata_reg <= {3'h0, tx_active_reg, rx_active_reg, csum_err_reg, half_reg, armed_reg};
			end else begin
				rdata_reg <= 8'h00;
			end
		end
	end

	assign reg_rdata_out = rdata_reg;

	// Sum of the data bytes really handed over, so the checksum check does not trust the reply image
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			tx_sum_reg <= 8'h00;
		end else if (ce_in) begin
			if (hdr_valid_in) begin
				tx_sum_reg <= 8'h00;
			end else if (tx_step && tx_idx_reg != `LOT_LAST_IDX) begin
				tx_sum_reg <= classic_add(tx_sum_reg, tx_byte_reg);
			end
		end
	end

	sequence s_resp_start;
		resp_hdr && armed_reg && ctrl_reg[0];
	endsequence

	sequence s_first_half_byte(int k);
		tx_active_reg && !half_reg && tx_idx_reg == k;
	endsequence

	a_resp_address: assert property (@(posedge mclk_in) disable iff (!nrst_in)
		s_resp_start |=> tx_valid_out && tx_byte_out == {2'b11, otp_in.node_address})
		else $error("response does not open with node address");
	a_resp_silent: assert property (@(posedge mclk_in) disable iff (!nrst_in)
		(resp_hdr && !armed_reg) |=> !tx_valid_out)
		else $error("response sent without a valid request");
	a_fuse_blocks: assert property (@(posedge mclk_in) disable iff (!nrst_in)
		$rose(armed_reg) |-> !$past(otp_in.commands_disable_fuse))
		else $error("request accepted with commands disabled");
	a_half_select: assert property (@(posedge mclk_in) disable iff (!nrst_in)
		$rose(armed_reg) |-> half_reg == ($past(rx_code_reg) == {1'b1, `LOT_CODE_SECOND}))
		else $error("reply half differs from last request code");
	a_req_fields: assert property (@(posedge mclk_in) disable iff (!nrst_in)
		$rose(armed_reg) |-> $past(rx_addr_reg) == {2'b11, otp_in.node_address} && $past(rx_app_reg) == `LOT_APP_CMD)
		else $error("request accepted with wrong address or command byte");
	a_resp_csum: assert property (@(posedge mclk_in) disable iff (!nrst_in)
		(tx_active_reg && tx_idx_reg == `LOT_LAST_IDX) |-> tx_byte_out == ~tx_sum_reg)
		else $error("checksum byte wrong");
	a_first_flags: assert property (@(posedge mclk_in) disable iff (!nrst_in)
		s_first_half_byte(3) |-> tx_byte_out[7:5] == {otp_in.default_setting, otp_in.error_report_off,
			otp_in.thermal_warning_level} && tx_byte_out[4:0] == 5'h1F)
		else $error("first reply byte 4 wrong");
	a_first_coeff: assert property (@(posedge mclk_in) disable iff (!nrst_in)
		s_first_half_byte(5) |-> tx_byte_out == otp_in.a11)
		else $error("first reply byte 6 is not a11");
	a_second_group: assert property (@(posedge mclk_in) disable iff (!nrst_in)
		(tx_active_reg && half_reg && tx_idx_reg == 4'h7) |-> tx_byte_out[5] && tx_byte_out[3:0] == otp_in.group_number)
		else $error("second reply byte 8 wrong");
	a_resp_length: assert property (@(posedge mclk_in) disable iff (!nrst_in)
		(s_resp_start ##1 (tx_ready_in && ce_in && !hdr_valid_in) [*8]) |=> tx_valid_out && tx_idx_reg == `LOT_LAST_IDX)
		else $error("reply not nine bytes long");
endmodule
`default_nettype wire

// *** lin_master_model.sv ***
// LIN master model: request frames out, in-frame replies in
`default_nettype none
module lin_master_model (
	input  wire logic              mclk_in,
	input  wire logic              tx_valid_in,
	input  wire logic [7:0]        tx_byte_in,
	output logic                   hdr_valid_out,
	output logic [7:0]             hdr_id_out,
	output lin_otp_pkg::lin_beat_t rx_out,
	output logic                   tx_ready_out
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		hdr_valid_out = 1'b0;
		hdr_id_out = 8'h00;
		rx_out = '0;
		tx_ready_out = 1'b0;
	end
	// Carry-wrapped sum of data only, inverted
	function automatic logic [7:0] csum(input logic [63:0] d);
		logic [8:0] s;
		s = 9'h000;
		for (int k = 0; k < 8; k++) begin
			s = s + {1'b0, d[63 - 8 * k -: 8]};
			s = {1'b0, s[7:0]} + {8'h00, s[8]};
		end
		return ~s[7:0];
	endfunction
	task automatic header(input logic [7:0] id);
		@(posedge mclk_in);
		hdr_valid_out <= 1'b1;
		hdr_id_out <= id;
		@(posedge mclk_in);
		hdr_valid_out <= 1'b0;
	endtask
	// A set bad flag spoils the checksum on purpose
	task automatic request(input logic [6:0] code, input logic [5:0] addr, input logic bad);
		logic [71:0] f;
		f[71:8] = {8'h80, 1'b1, code, 2'b11, addr, 40'hFF_FFFF_FFFF};
		f[7:0] = csum(f[71:8]) ^ {7'h00, bad};
		header(8'h3C);
		for (int k = 0; k < 9; k++) begin
			rx_out <= {1'b1, f[71 - 8 * k -: 8]};
			@(posedge mclk_in);
		end
		rx_out <= {1'b0, ~f[7:0]};
	endtask
	// Slow mode takes a byte only every other cycle
	task automatic response(input logic slow, output logic [71:0] r, output int n);
		r = '0;
		n = 0;
		header(8'h7D);
		// Ready already stands when the first reply byte appears
		tx_ready_out <= 1'b1;
		for (int c = 0; c < 30; c++) begin
			@(posedge mclk_in);
			if (tx_valid_in === 1'b1 && tx_ready_out === 1'b1) begin
				r = {r[63:0], tx_byte_in};
				n++;
			end
			tx_ready_out <= (c < 29) && (!slow || !tx_ready_out);
		end
	endtask
endmodule
`default_nettype wire

// *** tb.sv ***
// Testbench: settings readback request and reply frames
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic [6:0] code;
		logic [5:0] addr;
		logic       bad;
		logic       fuse;
		logic       reply;
	} row_t;
	logic                       mclk_in = 1'b0;
	logic                       nrst_in = 1'b0;
	logic                       ce = 1'b1;
	lin_otp_pkg::otp_settings_t otp;
	lin_otp_pkg::lin_beat_t     rx;
	logic                       hdr_valid, tx_ready, tx_valid, reg_we, reg_re;
	logic [7:0]                 hdr_id, tx_byte, reg_wdata, reg_rdata;
	logic [3:0]                 reg_addr;
	logic [71:0]                r;
	int                         n;
	int                         errors = 0;
	int                         num_checks = 0;
	row_t                       rows [6];
	always #10 mclk_in = ~mclk_in;
	lin_otp_settings_readback u_dut (.mclk_in(mclk_in), .nrst_in(nrst_in), .ce_in(ce), .otp_in(otp),
		.hdr_valid_in(hdr_valid), .hdr_id_in(hdr_id), .rx_in(rx), .tx_ready_in(tx_ready),
		.tx_valid_out(tx_valid), .tx_byte_out(tx_byte), .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
		.reg_we_in(reg_we), .reg_re_in(reg_re), .reg_rdata_out(reg_rdata));
	lin_master_model u_mst (.mclk_in(mclk_in), .tx_valid_in(tx_valid), .tx_byte_in(tx_byte),
		.hdr_valid_out(hdr_valid), .hdr_id_out(hdr_id), .rx_out(rx), .tx_ready_out(tx_ready));
	task automatic check(input logic [71:0] got, input logic [71:0] exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk_in);
		reg_we <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk_in);
		reg_we <= 1'b0;
	endtask
	task automatic reg_rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge mclk_in);
		reg_re <= 1'b1;
		reg_addr <= a;
		@(posedge mclk_in);
		reg_re <= 1'b0;
		#1;
		check({64'h0, reg_rdata}, {64'h0, exp});
	endtask
	function automatic logic [71:0] expect_reply(input logic second);
		logic [63:0] d;
		if (second) begin
			d = {2'b11, otp.node_address, otp.a21, otp.a22, otp.a23, otp.a31, otp.a32, otp.a33,
				otp.otp_lock_second, otp.modulation_rate_select, 1'b1, otp.thermal_control_enable, otp.group_number};
		end else begin
			d = {2'b11, otp.node_address, 6'h3F, otp.low_rate, otp.diagnostics_off_fuse, 8'hFF,
				otp.default_setting, otp.error_report_off, otp.thermal_warning_level, 5'h1F, otp.otp_lock_first,
				otp.commands_disable_fuse, otp.node_address, otp.a11, otp.a12, otp.a13};
		end
		return {d, u_mst.csum(d)};
	endfunction
	task automatic give_verdict();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		otp = 92'h0A5_C3F1_2345_6789_ABCD_EF12;
		reg_we = 1'b0;
		reg_re = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
		rows[0] = {7'h04, 6'h02, 1'b0, 1'b0, 1'b1};
		rows[1] = {7'h05, 6'h02, 1'b0, 1'b0, 1'b1};
		rows[2] = {7'h04, 6'h03, 1'b0, 1'b0, 1'b0};
		rows[3] = {7'h05, 6'h02, 1'b1, 1'b0, 1'b0};
		rows[4] = {7'h04, 6'h02, 1'b0, 1'b1, 1'b0};
		rows[5] = {7'h03, 6'h02, 1'b0, 1'b0, 1'b0};
		repeat (16) @(posedge mclk_in);
		nrst_in <= 1'b1;
		reg_rd(4'h0, 8'h01);
		reg_rd(4'h4, 8'h00);
		reg_rd(4'h2, 8'h00);
		foreach (rows[i]) begin
			otp.commands_disable_fuse <= rows[i].fuse;
			u_mst.request(rows[i].code, rows[i].addr, rows[i].bad);
			u_mst.response(i[0], r, n);
			check(72'(n), rows[i].reply ? 72'h9 : 72'h0);
			if (rows[i].reply) check(r, expect_reply(rows[i].code[0]));
		end
		// Refused rows leave the sticky checksum error and the last accepted half
		reg_rd(4'h4, 8'h06);
		reg_wr(4'h4, 8'h04);
		reg_rd(4'h4, 8'h02);
		// Only the later of two requests decides the half
		u_mst.request(7'h05, 6'h02, 1'b0);
		u_mst.request(7'h04, 6'h02, 1'b0);
		reg_rd(4'h4, 8'h01);
		u_mst.response(1'b0, r, n);
		check(r, expect_reply(1'b0));
		// Command disabled by software: reply slot stays silent
		reg_wr(4'h0, 8'h00);
		reg_rd(4'h0, 8'h00);
		u_mst.request(7'h05, 6'h02, 1'b0);
		u_mst.response(1'b0, r, n);
		check(72'(n), 72'h0);
		reg_wr(4'h0, 8'h01);
		// A write while the clock enable is low is lost
		ce <= 1'b0;
		reg_wr(4'h0, 8'h00);
		ce <= 1'b1;
		reg_rd(4'h0, 8'h01);
		// Reset in mid-run drops a pending arm and restores the enable
		u_mst.request(7'h05, 6'h02, 1'b0);
		reg_rd(4'h4, 8'h03);
		reg_wr(4'h0, 8'h00);
		nrst_in <= 1'b0;
		repeat (2) @(posedge mclk_in);
		nrst_in <= 1'b1;
		reg_rd(4'h0, 8'h01);
		reg_rd(4'h4, 8'h00);
		u_mst.response(1'b0, r, n);
		check(72'(n), 72'h0);
		give_verdict();
	end
endmodule
`default_nettype wire
